// ### verilog/scr_pkg.sv
// Constants for the device-wide control word decoder.
// Assumes a 29-bit serial command word, shifted in most significant bit first.
`default_nettype none
package scr_pkg;
    localparam int CMD_WIDTH = 29;
    localparam int CTRL_WIDTH = 22;
    localparam int RW_BIT = 28;
    localparam int ADDR_HI = 27;
    localparam int ADDR_LO = 22;
    localparam logic [5:0] CTRL_ADDR = 6'h00;
    localparam int CLAMP_HI = 21;
    localparam int CLAMP_LO = 18;
    localparam int CMP_OUT_HI = 17;
    localparam int CMP_OUT_LO = 14;
    localparam int CMP_POWER_BIT = 13;
    localparam int GROUND_PIN_BIT = 12;
    localparam int GUARD_ALARM_BIT = 11;
    localparam int CLAMP_ALARM_BIT = 10;
    localparam int SENSE_SHORT_BIT = 9;
    localparam int GUARD_EN_BIT = 8;
    localparam int GAIN_HI = 7;
    localparam int GAIN_LO = 6;
    localparam int THERMAL_EN_BIT = 5;
    localparam int THERMAL_HI = 4;
    localparam int THERMAL_LO = 3;
    localparam int LATCHED_ALARM_BIT = 2;
    localparam int USED_LO = 2;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 22'h000000;
    localparam logic [5:0] BIT_COUNT_MAX = 6'h1e;
endpackage
`default_nettype wire

// ### verilog/scr_control_decode.sv
// Device-wide control word: serial command capture, decode, storage, readback.
// Assumes the serial pins are asynchronous to clk; per-channel writes come from
// logic on clk.
// How it works
// - Zero channel and target bits select control word
// - One control word shared by all channels
// - Top command bit: zero writes, one reads back
// - Data bits 21:18 set clamp enables 3:0
// - Clamp enables follow most recent writer, per-channel write winning a same-cycle tie
// - Bits 17:14 comparator output enables, reset off
// - Remaining fields laid out at bits 13:2
// - Data bits 1:0 are ignored
// - One in output enable drives comparator output
// - Comparator power off at reset, bit 13
`timescale 1ns/100ps
`default_nettype none
module scr_control_decode (
    input wire logic clk,
    input wire logic reset,
    input wire logic serialClock,
    input wire logic frameSelect_n,
    input wire logic serialDataIn,
    input wire logic [3:0] chanClampWrite,
    input wire logic [3:0] chanClampData,
    input wire logic [3:0] chanCmpOutWrite,
    input wire logic [3:0] chanCmpOutData,
    output logic serialDataOut,
    output logic serialDataOutEnable,
    output logic [scr_pkg::CTRL_WIDTH-1:0] ctrlWord,
    output logic [3:0] clampEn,
    output logic [3:0] cmpOutEn,
    output logic comparatorPower,
    output logic groundPinPerChannel,
    output logic guardAlarmRoute,
    output logic clampAlarmRoute,
    output logic senseShortSelect,
    output logic guardEnable,
    output logic [1:0] measureGain,
    output logic thermalShutdownEnable,
    output logic [1:0] thermalThreshold,
    output logic latchedAlarm
);
    import scr_pkg::*;

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic [2:0] sclkSync;
    logic [2:0] frameSync;
    logic [1:0] sdiSync;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclkSync <= 3'h0;
            frameSync <= 3'h7;
            sdiSync <= 2'h0;
        end else begin
            sclkSync <= {sclkSync[1:0], serialClock};
            frameSync <= {frameSync[1:0], frameSelect_n};
            sdiSync <= {sdiSync[0], serialDataIn};
        end
    end

    logic inFrame;
    logic sclkFall;
    logic frameStart;
    logic frameEnd;
    assign inFrame = ~frameSync[1];
    assign sclkFall = sclkSync[2] & ~sclkSync[1] & inFrame;
    assign frameStart = frameSync[2] & ~frameSync[1];
    assign frameEnd = ~frameSync[2] & frameSync[1];

    // ****************************************
    // Command capture
    // ****************************************
    logic [CMD_WIDTH-1:0] cmdWord;
    logic [5:0] bitCount;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmdWord <= '0;
            bitCount <= 6'h00;
        end else if (frameStart) begin
            bitCount <= 6'h00;
        end else if (sclkFall) begin
            cmdWord <= {cmdWord[CMD_WIDTH-2:0], sdiSync[1]};
            if (bitCount != BIT_COUNT_MAX)
                bitCount <= bitCount + 6'h01;
        end
    end

    logic wordComplete;
    logic ctrlSelected;
    logic applyWrite;
    logic applyRead;
    assign wordComplete = frameEnd && (bitCount == 6'(CMD_WIDTH));
    assign ctrlSelected = cmdWord[ADDR_HI:ADDR_LO] == CTRL_ADDR;
    assign applyWrite = wordComplete && ctrlSelected && !cmdWord[RW_BIT];
    assign applyRead = wordComplete && ctrlSelected && cmdWord[RW_BIT];

    // ****************************************
    // Control word storage
    // ****************************************
    logic [CTRL_WIDTH-1:0] next_ctrlWord;

    always_comb begin
        next_ctrlWord = ctrlWord;
        if (applyWrite)
            next_ctrlWord = {cmdWord[CTRL_WIDTH-1:USED_LO], 2'h0};
        for (int i = 0; i < 4; i++) begin
            if (chanClampWrite[i])
                next_ctrlWord[CLAMP_LO+i] = chanClampData[i];
            if (chanCmpOutWrite[i])
                next_ctrlWord[CMP_OUT_LO+i] = chanCmpOutData[i];
        end
    end

    // Single copy for the whole device
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            ctrlWord <= CTRL_RESET;
        else
            ctrlWord <= next_ctrlWord;
    end

    assign clampEn = ctrlWord[CLAMP_HI:CLAMP_LO];
    assign cmpOutEn = ctrlWord[CMP_OUT_HI:CMP_OUT_LO];
    assign comparatorPower = ctrlWord[CMP_POWER_BIT];
    assign groundPinPerChannel = ctrlWord[GROUND_PIN_BIT];
    assign guardAlarmRoute = ctrlWord[GUARD_ALARM_BIT];
    assign clampAlarmRoute = ctrlWord[CLAMP_ALARM_BIT];
    assign senseShortSelect = ctrlWord[SENSE_SHORT_BIT];
    assign guardEnable = ctrlWord[GUARD_EN_BIT];
    assign measureGain = ctrlWord[GAIN_HI:GAIN_LO];
    assign thermalShutdownEnable = ctrlWord[THERMAL_EN_BIT];
    assign thermalThreshold = ctrlWord[THERMAL_HI:THERMAL_LO];
    assign latchedAlarm = ctrlWord[LATCHED_ALARM_BIT];

    // ****************************************
    // Readback shifter
    // ****************************************
    logic [CMD_WIDTH-1:0] readShift;
    logic readPending;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readShift <= '0;
            readPending <= 1'b0;
            serialDataOut <= 1'b0;
            serialDataOutEnable <= 1'b0;
        end else if (applyRead) begin
            readShift <= {7'h00, ctrlWord};
            readPending <= 1'b1;
            serialDataOutEnable <= 1'b0;
            serialDataOut <= 1'b0;
        end else if (frameStart && readPending) begin
            serialDataOut <= readShift[CMD_WIDTH-1];
            readShift <= {readShift[CMD_WIDTH-2:0], 1'b0};
            serialDataOutEnable <= 1'b1;
        end else if (sclkFall && serialDataOutEnable) begin
            serialDataOut <= readShift[CMD_WIDTH-1];
            readShift <= {readShift[CMD_WIDTH-2:0], 1'b0};
        end else if (frameEnd) begin
            readPending <= 1'b0;
            serialDataOutEnable <= 1'b0;
            serialDataOut <= 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic noChanWrite;
    assign noChanWrite = (chanClampWrite == 4'h0) && (chanCmpOutWrite == 4'h0);

    a_clamp_from_word: assert property (@(posedge clk) disable iff (reset)
        applyWrite && noChanWrite |=> clampEn == $past(cmdWord[CLAMP_HI:CLAMP_LO]))
        else $error("clamp enables not taken from command");
    a_cmp_out_from_word: assert property (@(posedge clk) disable iff (reset)
        applyWrite && noChanWrite |=> cmpOutEn == $past(cmdWord[CMP_OUT_HI:CMP_OUT_LO]))
        else $error("comparator output enables not taken from command");
    a_field_layout: assert property (@(posedge clk) disable iff (reset)
        applyWrite |=> ctrlWord[CMP_POWER_BIT:USED_LO] == $past(cmdWord[CMP_POWER_BIT:USED_LO]))
        else $error("field layout mismatch");
    a_unused_bits_zero: assert property (@(posedge clk) disable iff (reset)
        ctrlWord[1:0] == 2'h0)
        else $error("unused bits stored");
    a_other_addr_ignored: assert property (@(posedge clk) disable iff (reset)
        wordComplete && !ctrlSelected && noChanWrite |=> $stable(ctrlWord))
        else $error("write to other address changed control word");
    a_read_loads_word: assert property (@(posedge clk) disable iff (reset)
        applyRead && noChanWrite |=> readShift[CTRL_WIDTH-1:0] == $past(ctrlWord)
            && $stable(ctrlWord) ##1 readPending)
        else $error("readback not loaded");
    a_chan_clamp_write: assert property (@(posedge clk) disable iff (reset)
        (chanClampWrite != 4'h0) |=>
            ((clampEn ^ $past(chanClampData)) & $past(chanClampWrite)) == 4'h0)
        else $error("per-channel clamp write lost");
    a_chan_cmp_write: assert property (@(posedge clk) disable iff (reset)
        (chanCmpOutWrite != 4'h0) |=>
            ((cmpOutEn ^ $past(chanCmpOutData)) & $past(chanCmpOutWrite)) == 4'h0)
        else $error("per-channel comparator enable write lost");
    a_short_word_dropped: assert property (@(posedge clk) disable iff (reset)
        frameEnd && (bitCount != 6'(CMD_WIDTH)) && noChanWrite |=> $stable(ctrlWord))
        else $error("incomplete word applied");
    a_write_needs_word: assert property (@(posedge clk) disable iff (reset)
        !wordComplete && noChanWrite |=> $stable(ctrlWord))
        else $error("control word changed without a complete command");
    a_cmp_power_from_word: assert property (@(posedge clk) disable iff (reset)
        applyWrite |=> comparatorPower == $past(cmdWord[CMP_POWER_BIT]))
        else $error("comparator power not taken from command");
    a_read_drive_on: assert property (@(posedge clk) disable iff (reset)
        frameStart && readPending |=> serialDataOutEnable
            && serialDataOut == $past(readShift[CMD_WIDTH-1]))
        else $error("readback not driven at frame start");
    a_read_bit_shift: assert property (@(posedge clk) disable iff (reset)
        sclkFall && serialDataOutEnable |=> serialDataOut == $past(readShift[CMD_WIDTH-1]))
        else $error("readback bit out of order");
    a_read_drive_off: assert property (@(posedge clk) disable iff (reset)
        frameEnd |=> !serialDataOutEnable && !serialDataOut)
        else $error("readback still driven after frame end");
endmodule
`default_nettype wire

// ### tb/scr_host_model.sv
// Host side of the serial command link.
// Assumes clk is the 50 MHz system clock; a serial bit lasts 8 clk periods.
`timescale 1ns/100ps
`default_nettype none
module scr_host_model (
    input wire logic clk,
    input wire logic serialDataOut,
    output logic serialClock,
    output logic frameSelect_n,
    output logic serialDataIn
);
    initial begin
        serialClock = 1'b0;
        frameSelect_n = 1'b1;
        serialDataIn = 1'b0;
    end
    // Sends the top nBits of cmd; rd holds data out sampled before each fall
    task automatic frame(input logic [28:0] cmd, input int nBits, output logic [28:0] rd);
        rd = '0;
        @(negedge clk) frameSelect_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 28; i > 28 - nBits; i--) begin
            serialDataIn = cmd[i];
            serialClock = 1'b1;
            repeat (4) @(negedge clk);
            rd[i] = serialDataOut;
            serialClock = 1'b0;
            repeat (4) @(negedge clk);
        end
        frameSelect_n = 1'b1;
        // Released line shows the inverse of its last value
        serialDataIn = ~serialDataIn;
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ### tb/scr_control_decode_tb.sv
// Self-checking bench for the control word decoder.
// Assumes the host model paces frames; inputs change at clk falling edges.
`timescale 1ns/100ps
`default_nettype none
module scr_control_decode_tb;
    import scr_pkg::*;
    logic clk, reset, serialClock, frameSelect_n, serialDataIn, serialDataOut;
    logic serialDataOutEnable, comparatorPower, groundPinPerChannel, guardAlarmRoute;
    logic clampAlarmRoute, senseShortSelect, guardEnable, thermalShutdownEnable, latchedAlarm;
    logic [3:0] chanClampWrite, chanClampData, chanCmpOutWrite, chanCmpOutData, clampEn, cmpOutEn;
    logic [1:0] measureGain, thermalThreshold;
    logic [CTRL_WIDTH-1:0] ctrlWord, expWord;
    logic [28:0] rd;
    logic [21:0] pats [3] = '{22'h3fffff, 22'h155555, 22'h2aaaaa};
    int bad_count = 0;
    int n_checks = 0;
    wire [21:0] fields = {clampEn, cmpOutEn, comparatorPower, groundPinPerChannel,
        guardAlarmRoute, clampAlarmRoute, senseShortSelect, guardEnable, measureGain,
        thermalShutdownEnable, thermalThreshold, latchedAlarm, 2'b00};
    scr_host_model host (.clk(clk), .serialDataOut(serialDataOut), .serialClock(serialClock),
        .frameSelect_n(frameSelect_n), .serialDataIn(serialDataIn));
    scr_control_decode uut (.clk(clk), .reset(reset), .serialClock(serialClock),
        .frameSelect_n(frameSelect_n), .serialDataIn(serialDataIn),
        .chanClampWrite(chanClampWrite), .chanClampData(chanClampData),
        .chanCmpOutWrite(chanCmpOutWrite), .chanCmpOutData(chanCmpOutData),
        .serialDataOut(serialDataOut), .serialDataOutEnable(serialDataOutEnable),
        .ctrlWord(ctrlWord), .clampEn(clampEn), .cmpOutEn(cmpOutEn),
        .comparatorPower(comparatorPower), .groundPinPerChannel(groundPinPerChannel),
        .guardAlarmRoute(guardAlarmRoute), .clampAlarmRoute(clampAlarmRoute),
        .senseShortSelect(senseShortSelect), .guardEnable(guardEnable),
        .measureGain(measureGain), .thermalShutdownEnable(thermalShutdownEnable),
        .thermalThreshold(thermalThreshold), .latchedAlarm(latchedAlarm));
    task automatic chk(input string what, input logic [28:0] exp, input logic [28:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        reset = 1'b1;
        chanClampWrite = 4'h0;
        chanClampData = 4'h0;
        chanCmpOutWrite = 4'h0;
        chanCmpOutData = 4'h0;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        chk("ctrlWord reset", '0, ctrlWord);
        chk("comparatorPower reset", '0, comparatorPower);
        foreach (pats[k]) begin
            host.frame({7'h00, pats[k]}, 29, rd);
            expWord = pats[k] & 22'h3ffffc;
            chk("ctrlWord", expWord, ctrlWord);
            chk("fields", expWord, fields);
            chk("comparatorPower", expWord[13], comparatorPower);
        end
        host.frame({7'h04, 22'h3fffff}, 29, rd);
        chk("ctrlWord channel write", expWord, ctrlWord);
        host.frame({7'h00, 22'h000000}, 28, rd);
        chk("ctrlWord short frame", expWord, ctrlWord);
        @(negedge clk);
        chanClampWrite = 4'h1;
        chanClampData = 4'h1;
        chanCmpOutWrite = 4'h8;
        chanCmpOutData = 4'h0;
        @(negedge clk);
        chanClampWrite = 4'h0;
        chanCmpOutWrite = 4'h0;
        expWord[18] = 1'b1;
        expWord[17] = 1'b0;
        chk("clampEn", expWord[21:18], clampEn);
        chk("cmpOutEn", expWord[17:14], cmpOutEn);
        host.frame({1'b1, 6'h00, 22'h000000}, 29, rd);
        host.frame({1'b0, 6'h03, 22'h3fffff}, 29, rd);
        chk("readback", {7'h00, expWord}, rd);
        chk("serialDataOutEnable", '0, serialDataOutEnable);
        chk("ctrlWord after read", expWord, ctrlWord);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        chk("ctrlWord mid reset", '0, ctrlWord);
        chk("comparatorPower mid reset", '0, comparatorPower);
        report_and_stop();
    end
endmodule
`default_nettype wire
